// File: common/cmo_pkg.sv
`default_nettype none
package cmo_pkg;
  // special function register addresses of the three registers
  localparam logic [7:0] CMO_CTRL_ADDR = 8'h9A;
  localparam logic [7:0] CMO_MODE_ADDR = 8'h9C;
  localparam logic [7:0] CMO_MUX_ADDR  = 8'h9E;

  // control register fields
  localparam int CMO_EN_BIT    = 7;
  localparam int CMO_OUT_BIT   = 6;
  localparam int CMO_RISE_BIT  = 5;
  localparam int CMO_FALL_BIT  = 4;
  localparam int CMO_HYP_LSB   = 2;
  localparam int CMO_HYN_LSB   = 0;

  // mode register fields
  localparam int CMO_RIE_BIT   = 5;
  localparam int CMO_FIE_BIT   = 4;
  localparam int CMO_MD_LSB    = 0;

  // input select fields
  localparam int CMO_MXN_LSB   = 4;
  localparam int CMO_MXP_LSB   = 0;

  // reset values
  localparam logic [1:0] CMO_HYS_RST  = 2'h0;
  localparam logic [1:0] CMO_MD_RST   = 2'h2;
  localparam logic [2:0] CMO_MX_RST   = 3'h0;

  // synchroniser depth for the analog output
  localparam int CMO_SYNC_STAGES = 2;
endpackage
`default_nettype wire

// File: hw/cmo_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cmo_sync #(
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // level in and out
  input  wire logic async_i,
  output logic      sync_o
);
  logic [STAGES-1:0] stage_reg;

  // a single stage would let a metastable level reach the edge logic
  if (STAGES < 2) begin : g_bad_stages
    $error("cmo_sync needs at least two stages");
  end

  // first stage read only by the next stage
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[STAGES-2:0], async_i};
    end
  end

  assign sync_o = stage_reg[STAGES-1];
endmodule
`default_nettype wire

// File: hw/cmo_edge.sv
`timescale 1ns/1ps
`default_nettype none
module cmo_edge (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // synchronised level and qualifier
  input  wire logic level_i,
  input  wire logic enable_i,
  // one-cycle pulses
  output logic      rise_o,
  output logic      fall_o
);
  logic prev_reg;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_i;
    end
  end

  assign rise_o = enable_i & level_i & ~prev_reg;
  assign fall_o = enable_i & ~level_i & prev_reg;
endmodule
`default_nettype wire

// File: hw/cmo_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Power is on only while enabled; the routed output is low when off.
// - Bit 6 reads 1 when the positive input is above the negative, else 0.
// - Flag bit 5 sets on a rising edge, holds until cleared and resets to 0.
// - Flag bit 4 sets on a falling edge, holds until cleared and resets to 0.
// - Positive hysteresis bits 3:2 go from off at 0 to maximum at 3, reset 0.
// - Negative hysteresis bits 1:0 go from off at 0 to maximum at 3, reset 0.
// - Rising flag interrupts only while mode bit 5 is set; it resets to 0.
// - Falling flag interrupts only while mode bit 4 is set; it resets to 0.
// - Response mode runs fastest at 0 to slowest at 3 and resets to 2.
// - Select bits 6:4 choose the negative input and reset to 0.
// - Select bits 2:0 choose the positive input and reset to 0.
module cmo_top
  import cmo_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // analog core
  input  wire logic       cmp_out_async_i,
  output logic            cmp_power_o,
  output logic      [1:0] positive_hysteresis_o,
  output logic      [1:0] negative_hysteresis_o,
  output logic      [1:0] response_mode_o,
  output logic      [2:0] positive_input_select_o,
  output logic      [2:0] negative_input_select_o,
  // routed output and interrupt
  output logic            cmp_route_o,
  output logic            cmp_irq_o
);
  import cmo_pkg::*;

  logic       comparator_enable_reg;
  logic       rising_edge_flag_reg;
  logic       falling_edge_flag_reg;
  logic [1:0] positive_hysteresis_reg;
  logic [1:0] negative_hysteresis_reg;
  logic       rising_interrupt_enable_reg;
  logic       falling_interrupt_enable_reg;
  logic [1:0] response_mode_reg;
  logic [2:0] negative_input_select_reg;
  logic [2:0] positive_input_select_reg;
  logic       output_state;
  logic       rise_evt;
  logic       fall_evt;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_mux;
  logic [7:0] rdata_next;

  assign wr_ctrl = reg_wr_i & (reg_addr_i == CMO_CTRL_ADDR);
  assign wr_mode = reg_wr_i & (reg_addr_i == CMO_MODE_ADDR);
  assign wr_mux  = reg_wr_i & (reg_addr_i == CMO_MUX_ADDR);

  // analog output crosses into the clock domain here
  cmo_sync #(
    .STAGES (CMO_SYNC_STAGES)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (cmp_out_async_i),
    .sync_o     (output_state)
  );

  // edges ignored while unpowered: the core output is meaningless then
  cmo_edge u_edge (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .level_i    (output_state),
    .enable_i   (comparator_enable_reg),
    .rise_o     (rise_evt),
    .fall_o     (fall_evt)
  );

  // enable and tuning fields
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      comparator_enable_reg   <= 1'b0;
      positive_hysteresis_reg <= CMO_HYS_RST;
      negative_hysteresis_reg <= CMO_HYS_RST;
    end else if (wr_ctrl) begin
      comparator_enable_reg   <= reg_wdata_i[CMO_EN_BIT];
      positive_hysteresis_reg <= reg_wdata_i[CMO_HYP_LSB +: 2];
      negative_hysteresis_reg <= reg_wdata_i[CMO_HYN_LSB +: 2];
    end
  end

  // sticky flags: a new edge wins over a same-cycle clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rising_edge_flag_reg <= 1'b0;
    end else if (rise_evt) begin
      rising_edge_flag_reg <= 1'b1;
    end else if (wr_ctrl) begin
      rising_edge_flag_reg <= reg_wdata_i[CMO_RISE_BIT];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      falling_edge_flag_reg <= 1'b0;
    end else if (fall_evt) begin
      falling_edge_flag_reg <= 1'b1;
    end else if (wr_ctrl) begin
      falling_edge_flag_reg <= reg_wdata_i[CMO_FALL_BIT];
    end
  end

  // mode register; reserved bits are not stored
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rising_interrupt_enable_reg  <= 1'b0;
      falling_interrupt_enable_reg <= 1'b0;
      response_mode_reg            <= CMO_MD_RST;
    end else if (wr_mode) begin
      rising_interrupt_enable_reg  <= reg_wdata_i[CMO_RIE_BIT];
      falling_interrupt_enable_reg <= reg_wdata_i[CMO_FIE_BIT];
      response_mode_reg            <= reg_wdata_i[CMO_MD_LSB +: 2];
    end
  end

  // input select register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      negative_input_select_reg <= CMO_MX_RST;
      positive_input_select_reg <= CMO_MX_RST;
    end else if (wr_mux) begin
      negative_input_select_reg <= reg_wdata_i[CMO_MXN_LSB +: 3];
      positive_input_select_reg <= reg_wdata_i[CMO_MXP_LSB +: 3];
    end
  end

  // read data; reserved bits read zero since they are not stored and default to 0
  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr_i == CMO_CTRL_ADDR) begin
      rdata_next[CMO_EN_BIT]          = comparator_enable_reg;
      rdata_next[CMO_OUT_BIT]         = output_state;
      rdata_next[CMO_RISE_BIT]        = rising_edge_flag_reg;
      rdata_next[CMO_FALL_BIT]        = falling_edge_flag_reg;
      rdata_next[CMO_HYP_LSB +: 2]    = positive_hysteresis_reg;
      rdata_next[CMO_HYN_LSB +: 2]    = negative_hysteresis_reg;
    end else if (reg_addr_i == CMO_MODE_ADDR) begin
      rdata_next[CMO_RIE_BIT]         = rising_interrupt_enable_reg;
      rdata_next[CMO_FIE_BIT]         = falling_interrupt_enable_reg;
      rdata_next[CMO_MD_LSB +: 2]     = response_mode_reg;
    end else if (reg_addr_i == CMO_MUX_ADDR) begin
      rdata_next[CMO_MXN_LSB +: 3]    = negative_input_select_reg;
      rdata_next[CMO_MXP_LSB +: 3]    = positive_input_select_reg;
    end
  end

  // read data held between reads
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end

  // registered copies to the analog core
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_power_o             <= 1'b0;
      positive_hysteresis_o   <= CMO_HYS_RST;
      negative_hysteresis_o   <= CMO_HYS_RST;
      response_mode_o         <= CMO_MD_RST;
      positive_input_select_o <= CMO_MX_RST;
      negative_input_select_o <= CMO_MX_RST;
    end else begin
      cmp_power_o             <= comparator_enable_reg;
      positive_hysteresis_o   <= positive_hysteresis_reg;
      negative_hysteresis_o   <= negative_hysteresis_reg;
      response_mode_o         <= response_mode_reg;
      positive_input_select_o <= positive_input_select_reg;
      negative_input_select_o <= negative_input_select_reg;
    end
  end

  // routed output forced low while disabled
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_route_o <= 1'b0;
    end else begin
      cmp_route_o <= comparator_enable_reg & output_state;
    end
  end

  // interrupt request from the flags and their enables
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_irq_o <= 1'b0;
    end else begin
      cmp_irq_o <= (rising_edge_flag_reg & rising_interrupt_enable_reg) |
                   (falling_edge_flag_reg & falling_interrupt_enable_reg);
    end
  end

  a_power_follows_en: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    ##1 cmp_power_o == $past(comparator_enable_reg))
    else $error("power output does not follow enable");

  a_route_low_off: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !comparator_enable_reg ##1 !comparator_enable_reg |-> !cmp_route_o)
    else $error("routed output high while disabled");

  a_rise_sets_flag: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    rise_evt |=> rising_edge_flag_reg)
    else $error("rising edge did not set flag");

  a_rise_flag_holds: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    rising_edge_flag_reg && !wr_ctrl |=> rising_edge_flag_reg)
    else $error("rising flag dropped without a write");

  a_fall_sets_flag: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    fall_evt |=> falling_edge_flag_reg)
    else $error("falling edge did not set flag");

  a_fall_flag_holds: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    falling_edge_flag_reg && !wr_ctrl |=> falling_edge_flag_reg)
    else $error("falling flag dropped without a write");

  a_rise_irq_gated: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !rising_interrupt_enable_reg &&
      !(falling_edge_flag_reg && falling_interrupt_enable_reg)
      |=> !cmp_irq_o)
    else $error("rising flag raised interrupt while masked");

  a_fall_irq_path: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    falling_edge_flag_reg && falling_interrupt_enable_reg |=> cmp_irq_o)
    else $error("falling interrupt not raised");

  a_irq_equation: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    rising_edge_flag_reg && rising_interrupt_enable_reg |=> cmp_irq_o)
    else $error("rising interrupt not raised");

  a_single_edge: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    rise_evt |=> !rise_evt)
    else $error("one transition gave two rising pulses");

  a_mode_write: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    wr_mode |=> ##1 response_mode_o == $past(reg_wdata_i[1:0], 2))
    else $error("response mode not applied");

  a_mux_write: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    wr_mux |=> ##1 negative_input_select_o == $past(reg_wdata_i[6:4], 2))
    else $error("negative select not applied");

  a_psel_write: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    wr_mux |=> ##1
      positive_input_select_o == $past(reg_wdata_i[CMO_MXP_LSB +: 3], 2))
    else $error("positive select not applied");

  a_hyp_write: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    wr_ctrl |=> ##1
      positive_hysteresis_o == $past(reg_wdata_i[CMO_HYP_LSB +: 2], 2))
    else $error("positive hysteresis not applied");

  a_hyn_write: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    wr_ctrl |=> ##1
      negative_hysteresis_o == $past(reg_wdata_i[CMO_HYN_LSB +: 2], 2))
    else $error("negative hysteresis not applied");

  a_fall_single: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    fall_evt |=> !fall_evt)
    else $error("one transition gave two falling pulses");

  a_rise_clear: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    wr_ctrl && !reg_wdata_i[CMO_RISE_BIT] && !rise_evt
      |=> !rising_edge_flag_reg)
    else $error("rising flag not cleared by write");

  a_fall_clear: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    wr_ctrl && !reg_wdata_i[CMO_FALL_BIT] && !fall_evt
      |=> !falling_edge_flag_reg)
    else $error("falling flag not cleared by write");

  a_read_out_bit: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == CMO_CTRL_ADDR
      |=> reg_rdata_o[CMO_OUT_BIT] == $past(output_state))
    else $error("output state bit not read back");
endmodule
`default_nettype wire

// File: tb/cmo_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmo_core_model (
  // controls from the block
  input  wire logic       power_i,
  input  wire logic [1:0] hyp_i,
  input  wire logic [1:0] hyn_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [2:0] psel_i,
  input  wire logic [2:0] nsel_i,
  // analog decision
  output logic            out_o
);
  int   vpos [8];
  int   vneg [8];
  logic tgt;
  initial begin
    out_o = 1'b0;
    tgt   = 1'b0;
    foreach (vpos[i]) begin
      vpos[i] = 0;
      vneg[i] = 100;
    end
  end
  always #20 begin
    if (power_i) begin
      // output only moves once the band around the threshold is crossed
      if (out_o) begin
        tgt = vpos[psel_i] >= vneg[nsel_i] - 5 * hyn_i;
      end else begin
        tgt = vpos[psel_i] > vneg[nsel_i] + 5 * hyp_i;
      end
      // slower modes answer later
      out_o <= #(20 * (mode_i + 1)) tgt;
    end else begin
      // unpowered output means nothing, so it wanders
      out_o <= ~out_o;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_comparator_one_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_comparator_one_control;
  import cmo_pkg::*;
  logic       core_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic       cmp_out, pwr, route, irq;
  logic [1:0] hyp, hyn, md;
  logic [2:0] psel, nsel;
  int n_fail = 0;
  int compares = 0;
  int unsigned seed = 36982;
  int c, m, x;
  always #50 core_clk_i = ~core_clk_i;
  cmo_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .cmp_out_async_i(cmp_out), .cmp_power_o(pwr),
    .positive_hysteresis_o(hyp), .negative_hysteresis_o(hyn),
    .response_mode_o(md), .positive_input_select_o(psel),
    .negative_input_select_o(nsel), .cmp_route_o(route), .cmp_irq_o(irq));
  cmo_core_model u_core (.power_i(pwr), .hyp_i(hyp), .hyn_i(hyn),
    .mode_i(md), .psel_i(psel), .nsel_i(nsel), .out_o(cmp_out));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    @(negedge core_clk_i);
    d = reg_rdata_o;
  endtask
  task automatic wait_route(logic lvl);
    int k;
    for (k = 0; k < 60 && route !== lvl; k++) @(negedge core_clk_i);
    chk("route", {7'h0, lvl}, {7'h0, route});
    repeat (4) @(negedge core_clk_i);
  endtask
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    n_fail++;
    end_of_test();
  end
  initial begin
    logic [7:0] d;
    repeat (12) @(negedge core_clk_i);
    rst_i = 1'b0;
    rd(CMO_CTRL_ADDR, d);
    chk("ctrl reset", 8'h00, d & 8'hBF);
    rd(CMO_MODE_ADDR, d);
    chk("mode reset", 8'h02, d);
    rd(CMO_MUX_ADDR, d);
    chk("mux reset", 8'h00, d);
    chk("mode pin", 8'h02, {6'h0, md});
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      // reserved bits always written as zero
      c = rnd() & 32'h3F;
      m = rnd() & 32'h33;
      x = rnd() & 32'h77;
      wr(CMO_CTRL_ADDR, c[7:0]);
      wr(CMO_MODE_ADDR, m[7:0]);
      wr(CMO_MUX_ADDR, x[7:0]);
      rd(CMO_CTRL_ADDR, d);
      chk("ctrl rb", c[7:0], d & 8'hBF);
      rd(CMO_MODE_ADDR, d);
      chk("mode rb", m[7:0], d);
      rd(CMO_MUX_ADDR, d);
      chk("mux rb", x[7:0], d);
      chk("hyst", c[7:0] & 8'h0F, {4'h0, hyp, hyn});
      chk("sel", x[7:0], {1'b0, nsel, 1'b0, psel});
      chk("mode pin", m[7:0] & 8'h03, {6'h0, md});
      chk("irq", {7'h0, (c[5] & m[5]) | (c[4] & m[4])}, {7'h0, irq});
      chk("power", 8'h00, {7'h0, pwr});
    end
    rd(8'h9B, d);
    chk("unmapped", 8'h00, d);
    $display("test registers done");
    wr(CMO_MODE_ADDR, 8'h02);
    wr(CMO_MUX_ADDR, 8'h53);
    wr(CMO_CTRL_ADDR, 8'h80);
    chk("power", 8'h01, {7'h0, pwr});
    // false edges at power-up are cleared before interrupts go on
    repeat (10) @(negedge core_clk_i);
    wr(CMO_CTRL_ADDR, 8'h80);
    wr(CMO_MODE_ADDR, 8'h22);
    u_core.vpos[3] = 200;
    wait_route(1'b1);
    rd(CMO_CTRL_ADDR, d);
    chk("ctrl rise", 8'hE0, d);
    chk("irq rise", 8'h01, {7'h0, irq});
    wr(CMO_CTRL_ADDR, 8'h80);
    chk("irq clr", 8'h00, {7'h0, irq});
    u_core.vpos[3] = 0;
    wait_route(1'b0);
    rd(CMO_CTRL_ADDR, d);
    chk("ctrl fall", 8'h90, d);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(CMO_MODE_ADDR, 8'h12);
    chk("irq fall", 8'h01, {7'h0, irq});
    $display("test edges done");
    wr(CMO_CTRL_ADDR, 8'h00);
    for (int i = 0; i < 30; i++) begin
      @(negedge core_clk_i);
      chk("off route", 8'h00, {6'h0, pwr, route});
    end
    rd(CMO_CTRL_ADDR, d);
    chk("off flags", 8'h00, d & 8'hBF);
    $display("test disable done");
    // load non-reset values, then reset in mid-run
    wr(CMO_CTRL_ADDR, 8'h3F);
    wr(CMO_MODE_ADDR, 8'h31);
    wr(CMO_MUX_ADDR, 8'h77);
    chk("irq pre", 8'h01, {7'h0, irq});
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    rd(CMO_CTRL_ADDR, d);
    chk("ctrl rerst", 8'h00, d & 8'hBF);
    rd(CMO_MODE_ADDR, d);
    chk("mode rerst", 8'h02, d);
    rd(CMO_MUX_ADDR, d);
    chk("mux rerst", 8'h00, d);
    chk("irq rerst", 8'h00, {7'h0, irq});
    chk("mode pin rerst", 8'h02, {6'h0, md});
    chk("sel rerst", 8'h00, {1'b0, nsel, 1'b0, psel});
    $display("test mid reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
